// ---- hdl/sg_pkg.sv ----
package sg_pkg;
   // clock and timing
   localparam int CLK_NS = 10;
   localparam int TRSC_NS = 20;
   localparam int TRSC_CYC = (TRSC_NS + CLK_NS - 1) / CLK_NS;
   localparam int TRAS_NS = 60;
   localparam int TRAS_CYC = (TRAS_NS + CLK_NS - 1) / CLK_NS;
   localparam int TRP_NS = 30;
   localparam int TRP_CYC = (TRP_NS + CLK_NS - 1) / CLK_NS;
   localparam int TDPL_NS = 10;
   localparam int TDPL_CYC = (TDPL_NS + CLK_NS - 1) / CLK_NS;
   // address line positions
   localparam int A_BANK = 9;
   localparam int A_AUTO = 8;
   localparam int A_COLOR_LOAD_SELECT = 6;
   localparam int A_MASK_LOAD_SELECT = 5;
   // mode word fields
   localparam int MODE_OPT_LSB = 7;
   localparam int MODE_CL_LSB = 4;
   localparam int MODE_WRAP_BIT = 3;
   localparam int MODE_BL_LSB = 0;
   localparam logic [9:0] MODE_RST = 10'h020;
   localparam logic [2:0] BL_1 = 3'h0;
   localparam logic [2:0] BL_2 = 3'h1;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic [2:0] BL_PAGE = 3'h7;
   localparam logic [8:0] PAGE_WORDS = 9'h100;
   localparam logic [31:0] COLOR_RST = 32'h0;
   localparam logic [31:0] MASK_RST = 32'hFFFFFFFF;
   // pin codes {ras_n, cas_n, we_n, special_function_strobe}, cs_n low
   localparam logic [3:0] P_MODE_LOAD = 4'h0;
   localparam logic [3:0] P_SPECIAL_LOAD = 4'h1;
   localparam logic [3:0] P_REFRESH = 4'h2;
   localparam logic [3:0] P_PRECHARGE = 4'h8;
   localparam logic [3:0] P_ACTIVATE = 4'hC;
   localparam logic [3:0] P_ACT_MASKED = 4'hD;
   localparam logic [3:0] P_WRITE = 4'h4;
   localparam logic [3:0] P_BLOCK_WRITE = 4'h5;
   localparam logic [3:0] P_READ = 4'h6;
   localparam logic [3:0] P_NOP = 4'hE;

   typedef enum logic [3:0] {
      SG_NOP, SG_MODE_LOAD, SG_SPECIAL_LOAD, SG_ACTIVATE,
      SG_ACTIVATE_WITH_BIT_MASKING, SG_PRECHARGE, SG_READ, SG_WRITE,
      SG_BLOCK_WRITE, SG_REFRESH
   } sg_cmd_t;

   function automatic logic [8:0] sg_words(input logic [2:0] code);
      case (code)
         BL_2: sg_words = 9'h002;
         BL_4: sg_words = 9'h004;
         BL_8: sg_words = 9'h008;
         BL_PAGE: sg_words = PAGE_WORDS;
         default: sg_words = 9'h001;
      endcase
   endfunction

   function automatic logic [2:0] sg_lat(input logic [2:0] code);
      sg_lat = (code == 3'h0) ? 3'h1 : code;
   endfunction
endpackage

// ---- hdl/sg_bus_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface sg_bus_if;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic special_function_strobe;
   logic [9:0] addr;
   logic [3:0] dqm;
   logic [31:0] dq_c;
   logic dq_c_oe;
   logic [31:0] dq_d;
   logic dq_d_oe;
   logic [31:0] dq;
   // shared data wire; an undriven bus reads as zero here
   assign dq = dq_c_oe ? dq_c : (dq_d_oe ? dq_d : 32'h0);
   modport dev (input cs_n, ras_n, cas_n, we_n, special_function_strobe,
      addr, dqm, dq, output dq_d, dq_d_oe);
   modport ctl (output cs_n, ras_n, cas_n, we_n, special_function_strobe,
      addr, dqm, dq_c, dq_c_oe, input dq);
endinterface
`default_nettype wire

// ---- hdl/sg_dev.sv ----
`timescale 1ns/10ps
`default_nettype none
module sg_dev
   import sg_pkg::*;
(
   input wire logic CLK,
   input wire logic ARST_N,
   sg_bus_if.dev BUS,
   output logic [9:0] MODE_WORD,
   output logic [1:0] BANK_ACTIVE,
   output logic [1:0] BANK_PRECHARGING
);
   logic [9:0] mode_q;
   logic [31:0] color_q;
   logic [31:0] mask_q;
   logic [1:0] active_q;
   logic [1:0] per_bit_write_mask_q;
   logic [7:0] tras_q [2];
   logic [7:0] trp_q [2];
   logic [31:0] mem_q [512];
   logic [8:0] rd_left_q;
   logic [2:0] rd_dly_q;
   logic [7:0] rd_col_q;
   logic rd_bank_q;
   logic [8:0] wr_left_q;
   logic [7:0] wr_col_q;
   logic wr_bank_q;
   logic ap_pend_q;
   logic ap_bank_q;
   logic [8:0] ap_cnt_q;
   logic [31:0] dq_q;
   logic oe_q;
   logic [3:0] pins;
   logic sel;
   logic [2:0] cl;
   logic [8:0] bl;
   logic [7:0] wrap;
   logic [7:0] col;
   logic bank;
   logic [1:0] pre_go;
   logic ap_fire;
   logic wr_go;
   logic [8:0] wr_idx;
   logic [31:0] wr_en;
   logic [31:0] bw_en [8];

   assign pins = {BUS.ras_n, BUS.cas_n, BUS.we_n,
      BUS.special_function_strobe};
   assign sel = !BUS.cs_n;
   assign cl = sg_lat(mode_q[MODE_CL_LSB +: 3]);
   assign bl = sg_words(mode_q[MODE_BL_LSB +: 3]);
   assign wrap = 8'(bl - 9'h001);
   assign col = BUS.addr[7:0];
   assign bank = BUS.addr[A_BANK];

   function automatic logic [7:0] next_col(input logic [7:0] c,
      input logic [7:0] m);
      next_col = (c & ~m) | (8'(c + 8'h01) & m);
   endfunction

   // mode register
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mode_q <= MODE_RST;
      end else if (sel && pins == P_MODE_LOAD) begin
         mode_q <= BUS.addr;
      end
   end

   // special registers; both selects high loads neither (unknown case)
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         color_q <= COLOR_RST;
         mask_q <= MASK_RST;
      end else if (sel && pins == P_SPECIAL_LOAD) begin
         if (BUS.addr[A_COLOR_LOAD_SELECT] &&
            !BUS.addr[A_MASK_LOAD_SELECT]) begin
            color_q <= BUS.dq;
         end else if (BUS.addr[A_MASK_LOAD_SELECT] &&
            !BUS.addr[A_COLOR_LOAD_SELECT]) begin
            mask_q <= BUS.dq;
         end
      end
   end

   // explicit precharge, with bit 8 naming both banks, plus the scheduled auto precharge
   always_comb begin
      pre_go = 2'b00;
      if (sel && pins == P_PRECHARGE) begin
         if (BUS.addr[A_AUTO]) begin
            pre_go = 2'b11;
         end else begin
            pre_go[bank] = 1'b1;
         end
      end
      if (ap_fire) begin
         pre_go[ap_bank_q] = 1'b1;
      end
   end

   // auto precharge waits both for its slot and the row-active time
   assign ap_fire = ap_pend_q && ap_cnt_q == 9'h000 &&
      tras_q[ap_bank_q] == 8'h00;

   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : g_bank
         always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
               active_q[b] <= 1'b0;
               per_bit_write_mask_q[b] <= 1'b0;
               tras_q[b] <= 8'h00;
               trp_q[b] <= 8'h00;
            end else if (pre_go[b] && active_q[b]) begin
               active_q[b] <= 1'b0;
               trp_q[b] <= 8'(TRP_CYC);
            end else if (sel && bank == b && (pins == P_ACTIVATE ||
               pins == P_ACT_MASKED)) begin
               active_q[b] <= 1'b1;
               per_bit_write_mask_q[b] <= BUS.special_function_strobe;
               // one less, so zero is seen on the edge ending row time
               tras_q[b] <= 8'(TRAS_CYC - 1);
            end else begin
               if (tras_q[b] != 8'h00) begin
                  tras_q[b] <= tras_q[b] - 8'h01;
               end
               if (trp_q[b] != 8'h00) begin
                  trp_q[b] <= trp_q[b] - 8'h01;
               end
            end
         end
      end
   endgenerate

   // auto precharge scheduler; a count c fires on edge c+1
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ap_pend_q <= 1'b0;
         ap_bank_q <= 1'b0;
         ap_cnt_q <= 9'h000;
      end else if (sel && BUS.addr[A_AUTO] && (pins == P_READ ||
         pins == P_WRITE || pins == P_BLOCK_WRITE)) begin
         ap_pend_q <= 1'b1;
         ap_bank_q <= bank;
         if (pins == P_READ) begin
            // start one edge before the last word: cl+bl-2
            ap_cnt_q <= (9'(cl) + bl > 9'h003) ?
               9'(9'(cl) + bl - 9'h003) : 9'h000;
         end else if (pins == P_WRITE) begin
            ap_cnt_q <= (cl >= 3'h3) ? 9'(bl) : 9'(bl - 9'h001);
         end else begin
            ap_cnt_q <= (cl >= 3'h3) ? 9'h002 : 9'h001;
         end
      end else if (ap_fire) begin
         ap_pend_q <= 1'b0;
      end else if (ap_cnt_q != 9'h000) begin
         ap_cnt_q <= ap_cnt_q - 9'h001;
      end
   end

   // read burst and output drive
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rd_left_q <= 9'h000;
         rd_dly_q <= 3'h0;
         rd_col_q <= 8'h00;
         rd_bank_q <= 1'b0;
         dq_q <= 32'h0;
         oe_q <= 1'b0;
      end else begin
         if (sel && pins == P_READ) begin
            rd_left_q <= bl;
            rd_dly_q <= cl - 3'h1;
            rd_col_q <= col;
            rd_bank_q <= bank;
         end else if (rd_dly_q != 3'h0) begin
            rd_dly_q <= rd_dly_q - 3'h1;
         end else if (rd_left_q != 9'h000) begin
            rd_left_q <= rd_left_q - 9'h001;
            rd_col_q <= next_col(rd_col_q, wrap);
         end
         if (rd_dly_q == 3'h0 && rd_left_q != 9'h000) begin
            dq_q <= mem_q[{rd_bank_q, rd_col_q}];
            oe_q <= 1'b1;
         end else begin
            oe_q <= 1'b0;
         end
      end
   end

   // write burst; first word arrives with the command
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wr_left_q <= 9'h000;
         wr_col_q <= 8'h00;
         wr_bank_q <= 1'b0;
      end else if (sel && pins == P_WRITE) begin
         wr_left_q <= bl - 9'h001;
         wr_col_q <= next_col(col, wrap);
         wr_bank_q <= bank;
      end else if (sel && (pins == P_READ || pins == P_BLOCK_WRITE)) begin
         wr_left_q <= 9'h000;
      end else if (wr_left_q != 9'h000) begin
         wr_left_q <= wr_left_q - 9'h001;
         wr_col_q <= next_col(wr_col_q, wrap);
      end
   end

   assign wr_go = (sel && pins == P_WRITE) || wr_left_q != 9'h000;
   assign wr_idx = (sel && pins == P_WRITE) ? {bank, col} :
      {wr_bank_q, wr_col_q};

   // per-bit mask only in a masked-activated bank; byte mask wins
   always_comb begin
      wr_en = {{8{!BUS.dqm[3]}}, {8{!BUS.dqm[2]}}, {8{!BUS.dqm[1]}},
         {8{!BUS.dqm[0]}}};
      if (per_bit_write_mask_q[wr_idx[8]]) begin
         wr_en = wr_en & mask_q;
      end
   end

   genvar c;
   generate
      for (c = 0; c < 8; c++) begin : g_col
         always_comb begin
            bw_en[c] = 32'h0;
            for (int y = 0; y < 4; y++) begin
               if (!BUS.dqm[y] && BUS.dq[8 * y + c]) begin
                  bw_en[c][8 * y +: 8] = 8'hFF;
               end
            end
            if (per_bit_write_mask_q[bank]) begin
               bw_en[c] = bw_en[c] & mask_q;
            end
         end
      end
   endgenerate

   // cell array; no reset so it maps to plain storage
   always_ff @(posedge CLK) begin
      if (sel && pins == P_BLOCK_WRITE) begin
         for (int k = 0; k < 8; k++) begin
            mem_q[{bank, col[7:3], 3'(k)}] <=
               (mem_q[{bank, col[7:3], 3'(k)}] & ~bw_en[k]) |
               (color_q & bw_en[k]);
         end
      end else if (wr_go) begin
         mem_q[wr_idx] <= (mem_q[wr_idx] & ~wr_en) | (BUS.dq & wr_en);
      end
   end

   assign BUS.dq_d = dq_q;
   assign BUS.dq_d_oe = oe_q;
   assign MODE_WORD = mode_q;
   assign BANK_ACTIVE = active_q;
   assign BANK_PRECHARGING = {trp_q[1] != 8'h00, trp_q[0] != 8'h00};
endmodule
`default_nettype wire

// ---- hdl/sg_ctl.sv ----
`timescale 1ns/10ps
`default_nettype none
module sg_ctl
   import sg_pkg::*;
(
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic CMD_VALID,
   input wire sg_cmd_t CMD,
   input wire logic BANK,
   input wire logic AUTO,
   input wire logic [9:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WMASK,
   output logic CMD_READY,
   output logic WDATA_TAKE,
   output logic [31:0] RDATA,
   output logic RDATA_VALID,
   sg_bus_if.ctl BUS
);
   logic [4:0] pin_q;
   logic [9:0] addr_q;
   logic [3:0] dqm_q;
   logic [31:0] dq_q;
   logic oe_q;
   logic [2:0] cl_q;
   logic [8:0] bl_q;
   logic [3:0] gap_q;
   logic [7:0] tras_q [2];
   logic [3:0] wrec_q;
   logic [8:0] wr_left_q;
   logic [3:0] rd_dly_q;
   logic [8:0] rd_left_q;
   logic [31:0] rdata_q;
   logic rvalid_q;
   logic go;
   logic pre_ok;
   logic [3:0] code;
   logic [9:0] addr_d;

   // precharge only once row-active and write recovery have passed;
   // a read is cut no earlier than one word before its last one
   assign pre_ok = wrec_q == 4'h0 && rd_dly_q == 4'h0 &&
      rd_left_q <= 9'h004 &&
      (AUTO ? (tras_q[0] == 8'h00 && tras_q[1] == 8'h00) :
      tras_q[BANK] == 8'h00);
   assign CMD_READY = gap_q == 4'h0 && wr_left_q == 9'h000 &&
      (CMD != SG_PRECHARGE || pre_ok);
   assign go = CMD_VALID && CMD_READY;
   assign WDATA_TAKE = (go && (CMD == SG_WRITE || CMD == SG_BLOCK_WRITE ||
      CMD == SG_SPECIAL_LOAD)) || wr_left_q != 9'h000;

   always_comb begin
      addr_d = {BANK, AUTO, ADDR[7:0]};
      case (CMD)
         SG_MODE_LOAD: begin
            code = P_MODE_LOAD;
            addr_d = ADDR;
         end
         SG_SPECIAL_LOAD: begin
            code = P_SPECIAL_LOAD;
            addr_d = ADDR;
            if (ADDR[A_COLOR_LOAD_SELECT]) begin
               addr_d[A_MASK_LOAD_SELECT] = 1'b0;
            end
         end
         SG_ACTIVATE: begin
            code = P_ACTIVATE;
            addr_d = {BANK, ADDR[8:0]};
         end
         SG_ACTIVATE_WITH_BIT_MASKING: begin
            code = P_ACT_MASKED;
            addr_d = {BANK, ADDR[8:0]};
         end
         SG_PRECHARGE: code = P_PRECHARGE;
         SG_READ: code = P_READ;
         SG_WRITE: code = P_WRITE;
         SG_BLOCK_WRITE: code = P_BLOCK_WRITE;
         SG_REFRESH: code = P_REFRESH;
         default: code = P_NOP;
      endcase
   end

   // pins come from flops, so the device sees a command one edge late
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pin_q <= 5'h1E;
         addr_q <= 10'h000;
         dqm_q <= 4'hF;
         dq_q <= 32'h0;
         oe_q <= 1'b0;
      end else begin
         pin_q <= go ? {1'b0, code} : {1'b1, P_NOP};
         addr_q <= go ? addr_d : addr_q;
         dqm_q <= WDATA_TAKE ? WMASK : 4'hF;
         dq_q <= WDATA_TAKE ? WDATA : dq_q;
         oe_q <= WDATA_TAKE;
      end
   end

   // shadow of the programmed latency and length
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cl_q <= sg_lat(MODE_RST[MODE_CL_LSB +: 3]);
         bl_q <= sg_words(MODE_RST[MODE_BL_LSB +: 3]);
      end else if (go && CMD == SG_MODE_LOAD) begin
         cl_q <= sg_lat(ADDR[MODE_CL_LSB +: 3]);
         bl_q <= sg_words(ADDR[MODE_BL_LSB +: 3]);
      end
   end

   // spacing after register loads, counted from the pin cycle
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         gap_q <= 4'h0;
      end else if (go && (CMD == SG_MODE_LOAD ||
         CMD == SG_SPECIAL_LOAD)) begin
         gap_q <= 4'(TRSC_CYC - 1);
      end else if (gap_q != 4'h0) begin
         gap_q <= gap_q - 4'h1;
      end
   end

   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : g_bank
         always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
               tras_q[b] <= 8'h00;
            end else if (go && BANK == b && (CMD == SG_ACTIVATE ||
               CMD == SG_ACTIVATE_WITH_BIT_MASKING)) begin
               tras_q[b] <= 8'(TRAS_CYC);
            end else if (tras_q[b] != 8'h00) begin
               tras_q[b] <= tras_q[b] - 8'h01;
            end
         end
      end
   endgenerate

   // write burst data and the recovery before precharge
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wr_left_q <= 9'h000;
         wrec_q <= 4'h0;
      end else if (go && CMD == SG_WRITE) begin
         wr_left_q <= bl_q - 9'h001;
         wrec_q <= 4'(TDPL_CYC);
      end else begin
         if (wr_left_q != 9'h000) begin
            wr_left_q <= wr_left_q - 9'h001;
            wrec_q <= 4'(TDPL_CYC);
         end else if (wrec_q != 4'h0) begin
            wrec_q <= wrec_q - 4'h1;
         end
      end
   end

   // read capture: latency plus one edge for the registered pins
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rd_dly_q <= 4'h0;
         rd_left_q <= 9'h000;
         rdata_q <= 32'h0;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= 1'b0;
         if (go && CMD == SG_READ) begin
            rd_dly_q <= 4'(cl_q) + 4'h1;
            rd_left_q <= bl_q;
         end else if (rd_dly_q != 4'h0) begin
            rd_dly_q <= rd_dly_q - 4'h1;
         end else if (rd_left_q != 9'h000) begin
            rd_left_q <= rd_left_q - 9'h001;
            rdata_q <= BUS.dq;
            rvalid_q <= 1'b1;
         end
      end
   end

   assign BUS.cs_n = pin_q[4];
   assign BUS.ras_n = pin_q[3];
   assign BUS.cas_n = pin_q[2];
   assign BUS.we_n = pin_q[1];
   assign BUS.special_function_strobe = pin_q[0];
   assign BUS.addr = addr_q;
   assign BUS.dqm = dqm_q;
   assign BUS.dq_c = dq_q;
   assign BUS.dq_c_oe = oe_q;
   assign RDATA = rdata_q;
   assign RDATA_VALID = rvalid_q;
endmodule
`default_nettype wire

// ---- testbench/sg_bus_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module sg_bus_props
   import sg_pkg::*;
(
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic special_function_strobe,
   input wire logic [9:0] addr,
   input wire logic dq_c_oe,
   input wire logic dq_d_oe
);
   logic [3:0] pins;
   logic [9:0] mode_q;
   logic [3:0] age_q [2];
   logic rd, wr, bw, ld, sl, act, pre;
   assign pins = {ras_n, cas_n, we_n, special_function_strobe};
   assign rd = !cs_n && pins == P_READ;
   assign wr = !cs_n && pins == P_WRITE;
   assign bw = !cs_n && pins == P_BLOCK_WRITE;
   assign ld = !cs_n && pins == P_MODE_LOAD;
   assign sl = !cs_n && pins == P_SPECIAL_LOAD;
   assign pre = !cs_n && pins == P_PRECHARGE;
   assign act = !cs_n && (pins == P_ACTIVATE || pins == P_ACT_MASKED);
   // own copy of the mode word, so timing checks follow every reload
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mode_q <= MODE_RST;
      end else if (ld) begin
         mode_q <= addr;
      end
   end
   // saturating age since activate; saturation keeps idle banks legal
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         age_q[0] <= 4'hF;
         age_q[1] <= 4'hF;
      end else begin
         for (int b = 0; b < 2; b++) begin
            if (act && addr[9] == b[0]) begin
               age_q[b] <= 4'h0;
            end else if (age_q[b] != 4'hF) begin
               age_q[b] <= age_q[b] + 4'h1;
            end
         end
      end
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);
   sequence burst4_s;
      dq_d_oe [*4] ##1 !dq_d_oe;
   endsequence
   sequence cl2_bl4_s;
      rd && mode_q[6:4] == 3'h2 && mode_q[2:0] == BL_4;
   endsequence
   load_gap_a: assert property ((ld || sl) |=> cs_n)
      else $error("command too soon after a register load");
   select_clash_a: assert property (sl |-> !(addr[6] && addr[5]))
      else $error("special load with both selects");
   special_payload_a: assert property (sl |-> dq_c_oe)
      else $error("special load without payload on data bus");
   write_words_a: assert property (wr && mode_q[2:0] == BL_4 |-> dq_c_oe [*4])
      else $error("write burst words missing");
   read_release_a: assert property (cl2_bl4_s |-> ##3 burst4_s)
      else $error("read burst length or release wrong");
   read_cl3_a: assert property (rd && mode_q[6:4] == 3'h3 |-> ##4 dq_d_oe)
      else $error("first read word late at latency three");
   read_source_a: assert property ($rose(dq_d_oe) |->
      $past(rd, 3) || $past(rd, 4))
      else $error("device drove data without a read");
   bus_clash_a: assert property (!(dq_c_oe && dq_d_oe))
      else $error("both ends drive the data bus");
   block_enables_a: assert property (bw |-> dq_c_oe)
      else $error("block write without column enables");
   row_time_a: assert property (pre |->
      ((!addr[8] && addr[9]) || age_q[0] >= TRAS_CYC - 1) &&
      ((!addr[8] && !addr[9]) || age_q[1] >= TRAS_CYC - 1))
      else $error("precharge before row active time");
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import sg_pkg::*;
   localparam logic [31:0] C1 = 32'h1357_9BDF;
   localparam logic [31:0] C2 = 32'hFEDC_BA98;
   localparam logic [31:0] EN = 32'h5AF0_0FC3;
   localparam logic [31:0] MSK = 32'h0000_FFFF;
   logic CLK = 1'b0;
   logic ARST_N = 1'b0;
   logic CMD_VALID = 1'b0;
   sg_cmd_t CMD = SG_NOP;
   logic BANK = 1'b0;
   logic AUTO = 1'b0;
   logic [9:0] ADDR = 10'h000;
   logic [31:0] WDATA = 32'h0;
   logic [3:0] WMASK = 4'h0;
   logic CMD_READY, WDATA_TAKE, RDATA_VALID;
   logic [31:0] RDATA;
   logic [9:0] MODE_WORD;
   logic [1:0] BANK_ACTIVE, BANK_PRECHARGING;
   logic [1:0] was = 2'h0;
   int clr [2];
   int cyc = 0;
   int acc = 0;
   int n_errors = 0;
   int n_checks = 0;
   int l2, l3;
   logic [31:0] a_w [8] = '{32'h1111_0001, 32'h2222_0002, 32'h3333_0003,
      32'h4444_0004, 32'h0, 32'h0, 32'h0, 32'h0};
   logic [31:0] m0 [8];
   sg_bus_if bus();
   sg_dev i_sg_dev (.CLK(CLK), .ARST_N(ARST_N), .BUS(bus),
      .MODE_WORD(MODE_WORD), .BANK_ACTIVE(BANK_ACTIVE),
      .BANK_PRECHARGING(BANK_PRECHARGING));
   sg_ctl i_sg_ctl (.CLK(CLK), .ARST_N(ARST_N), .CMD_VALID(CMD_VALID),
      .CMD(CMD), .BANK(BANK), .AUTO(AUTO), .ADDR(ADDR), .WDATA(WDATA),
      .WMASK(WMASK), .CMD_READY(CMD_READY), .WDATA_TAKE(WDATA_TAKE),
      .RDATA(RDATA), .RDATA_VALID(RDATA_VALID), .BUS(bus));
   sg_bus_props props (.CLK(CLK), .ARST_N(ARST_N), .cs_n(bus.cs_n),
      .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n),
      .special_function_strobe(bus.special_function_strobe),
      .addr(bus.addr), .dq_c_oe(bus.dq_c_oe), .dq_d_oe(bus.dq_d_oe));
   always #(CLK_NS / 2) CLK = ~CLK;
   always @(posedge CLK) cyc <= cyc + 1;
   // note the cycle on which each bank leaves the active state
   always @(posedge CLK) begin
      #1;
      for (int b = 0; b < 2; b++) begin
         if (was[b] === 1'b1 && BANK_ACTIVE[b] === 1'b0) clr[b] = cyc;
         was[b] = BANK_ACTIVE[b];
      end
   end
   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic op(input sg_cmd_t c, input logic b, au,
      input logic [9:0] a, input logic [31:0] d, input logic [3:0] m);
      int n;
      // let an edge pass so valid never drops and rises in one step
      if (acc == cyc) begin
         @(posedge CLK);
         #1;
      end
      CMD = c;
      BANK = b;
      AUTO = au;
      ADDR = a;
      WDATA = d;
      WMASK = m;
      CMD_VALID = 1'b1;
      n = 0;
      while (CMD_READY !== 1'b1 && n < 40) begin
         @(posedge CLK);
         #1;
         n++;
      end
      check("ready", {31'h0, CMD_READY}, 32'h1);
      @(posedge CLK);
      #1;
      CMD_VALID = 1'b0;
      acc = cyc;
   endtask
   task automatic ld_mode(input logic [9:0] v);
      op(SG_MODE_LOAD, 1'b0, 1'b0, v, 32'h0, 4'h0);
      @(posedge CLK);
      #1;
      check("mode", {22'h0, MODE_WORD}, {22'h0, v});
   endtask
   task automatic wr4(input logic b, au, input logic [9:0] a,
      input logic [31:0] d [8], input logic [3:0] m1);
      op(SG_WRITE, b, au, a, d[0], 4'h0);
      for (int i = 1; i < 4; i++) begin
         WDATA = d[i];
         WMASK = (i == 1) ? m1 : 4'h0;
         check("take", {31'h0, WDATA_TAKE}, 32'h1);
         @(posedge CLK);
         #1;
      end
   endtask
   task automatic rd(input logic b, au, input logic [9:0] a,
      input logic [31:0] e [8], input int nw, output int lat);
      int k;
      k = 0;
      lat = 0;
      op(SG_READ, b, au, a, 32'h0, 4'h0);
      for (int t = 0; t < 30 && k < nw; t++) begin
         if (RDATA_VALID === 1'b1) begin
            if (k == 0) lat = cyc - acc;
            check("rdata", RDATA, e[k]);
            k++;
         end
         @(posedge CLK);
         #1;
      end
      check("words", 32'(k), 32'(nw));
   endtask
   function automatic logic [31:0] blk(input int c);
      for (int y = 0; y < 4; y++) begin
         blk[8*y+:8] = (EN[8*y+c] && y != 2) ? C2[8*y+:8] : C1[8*y+:8];
      end
   endfunction
   task automatic sc_wrap();
      ld_mode(10'h022);
      op(SG_ACTIVATE, 1'b0, 1'b0, 10'h000, 32'h0, 4'h0);
      wr4(1'b0, 1'b0, 10'h000, a_w, 4'h0);
      rd(1'b0, 1'b0, 10'h002, '{a_w[2], a_w[3], a_w[0], a_w[1],
         32'h0, 32'h0, 32'h0, 32'h0}, 4, l2);
      ld_mode(10'h032);
      rd(1'b0, 1'b0, 10'h000, a_w, 4, l3);
      check("latency", 32'(l3 - l2), 32'h1);
   endtask
   task automatic sc_mask();
      op(SG_SPECIAL_LOAD, 1'b0, 1'b0, 10'h020, MSK, 4'h0);
      op(SG_PRECHARGE, 1'b0, 1'b0, 10'h000, 32'h0, 4'h0);
      @(posedge CLK);
      #1;
      check("closing", {30'h0, BANK_ACTIVE[0], BANK_PRECHARGING[0]}, 32'h1);
      repeat (TRP_CYC) @(posedge CLK);
      #1;
      check("idle", {31'h0, BANK_PRECHARGING[0]}, 32'h0);
      op(SG_ACTIVATE_WITH_BIT_MASKING, 1'b0, 1'b0, 10'h000, 32'h0, 4'h0);
      for (int i = 0; i < 8; i++) m0[i] = ~a_w[i];
      wr4(1'b0, 1'b0, 10'h000, m0, 4'h1);
      for (int i = 0; i < 8; i++) m0[i] = (~a_w[i] & MSK) | (a_w[i] & ~MSK);
      m0[1][7:0] = a_w[1][7:0];
      rd(1'b0, 1'b0, 10'h000, m0, 4, l3);
   endtask
   task automatic sc_block();
      logic [31:0] e [8];
      ld_mode(10'h033);
      op(SG_SPECIAL_LOAD, 1'b0, 1'b0, 10'h040, C1, 4'h0);
      op(SG_ACTIVATE, 1'b1, 1'b0, 10'h000, 32'h0, 4'h0);
      op(SG_BLOCK_WRITE, 1'b1, 1'b0, 10'h008, 32'hFFFF_FFFF, 4'h0);
      op(SG_SPECIAL_LOAD, 1'b0, 1'b0, 10'h060, C2, 4'h0);
      repeat (6) @(posedge CLK);
      #1;
      op(SG_BLOCK_WRITE, 1'b1, 1'b1, 10'h00B, EN, 4'h4);
      repeat (10) @(posedge CLK);
      #1;
      check("bw close", 32'(clr[1] - acc), 32'h4);
      op(SG_ACTIVATE, 1'b1, 1'b0, 10'h000, 32'h0, 4'h0);
      for (int c = 0; c < 8; c++) e[c] = blk(c);
      rd(1'b1, 1'b0, 10'h008, e, 8, l3);
   endtask
   task automatic sc_autoclose();
      int t0;
      ld_mode(10'h022);
      wr4(1'b1, 1'b1, 10'h010, a_w, 4'h0);
      repeat (4) @(posedge CLK);
      #1;
      check("wr close", 32'(clr[1] - acc), 32'h5);
      rd(1'b0, 1'b1, 10'h000, m0, 4, l2);
      check("rd close", 32'(clr[0] - acc), 32'h5);
      repeat (6) @(posedge CLK);
      #1;
      op(SG_ACTIVATE, 1'b0, 1'b0, 10'h000, 32'h0, 4'h0);
      t0 = acc;
      // no column enabled; its nominal close falls before row time ends
      op(SG_BLOCK_WRITE, 1'b0, 1'b1, 10'h000, 32'h0, 4'h0);
      repeat (12) @(posedge CLK);
      #1;
      check("late close", 32'(clr[0] - t0), 32'(1 + TRAS_CYC));
   endtask
   // generous bound: the whole sequence needs fewer than 150 cycles
   initial begin
      #(CLK_NS * 5000);
      n_errors++;
      complete_run();
   end
   initial begin
      repeat (4) @(posedge CLK);
      #1;
      ARST_N = 1'b1;
      sc_wrap();
      sc_mask();
      sc_block();
      sc_autoclose();
      complete_run();
   end
endmodule
`default_nettype wire
